// ### sct_params.svh
// Purpose: constants for the supervisor call and trap unit
// Assumes: instruction bit 0 is the msb (insn[31]); fields below are lsb-indexed
// Notes: definitions only
`ifndef SCT_PARAMS_SVH
`define SCT_PARAMS_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define SCT_OP_SVC 6'h11
`define SCT_OP_TRAP_RR 6'h1F
`define SCT_XO_TRAP_RR 10'h044
`define SCT_OP_TRAP_IMM 6'h02

// ----------------------------------------------------------------
// instruction fields (lsb-indexed)
// ----------------------------------------------------------------
`define SCT_OPC_HI 31
`define SCT_OPC_LO 26
`define SCT_IDX_HI 11
`define SCT_IDX_LO 5
`define SCT_ABS_POS 1
`define SCT_LNK_POS 0
`define SCT_TOM_HI 25
`define SCT_TOM_LO 21
`define SCT_XO_HI 10
`define SCT_XO_LO 1

// ----------------------------------------------------------------
// machine state bits (lsb-indexed, 32-bit view)
// ----------------------------------------------------------------
`define SCT_MSR_EE 15
`define SCT_MSR_PR 14
`define SCT_MSR_FE 11
`define SCT_MSR_IP 6

// ----------------------------------------------------------------
// vectors
// ----------------------------------------------------------------
`define SCT_ABS_OFFSET 32'h0000_1FE0
`define SCT_BASE_LOW 32'h0000_0000
`define SCT_BASE_HIGH 32'hFFF0_0000

// ----------------------------------------------------------------
// register map (byte offsets) and reset values
// ----------------------------------------------------------------
`define SCT_REG_CTRL 5'h00
`define SCT_REG_STATUS 5'h04
`define SCT_REG_MASK 5'h08
`define SCT_REG_VECTOR 5'h0C
`define SCT_REG_COUNT 5'h10
`define SCT_CTRL_RST 32'h0000_0001
`define SCT_MASK_RST 4'h0
`define SCT_EV_SVC 0
`define SCT_EV_TRAP 1
`define SCT_EV_ILL 2
`define SCT_EV_SYS 3

`endif

// ### sct_pkg.sv
// Purpose: types for the supervisor call and trap unit
// Assumes: constants live in sct_params.svh
// Notes: only types here
package sct_pkg;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [31:0] sct_word_t; // instruction / 32-bit register
  typedef logic [63:0] sct_dword_t; // general register value
  typedef logic [3:0] sct_events_t; // sticky event vector
endpackage

// ### sct_unit.sv
// Purpose: executes supervisor call and doubleword trap instructions
// Assumes: one issue per ISSUE_I pulse; operands valid with it
// Notes: results stand one cycle after issue; strobes are one-cycle pulses, values hold
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "sct_params.svh"

module sct_unit #(
  parameter bit IS_64 = 1'b1 // doubleword traps implemented
) (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  // issue side
  input wire logic ISSUE_I,
  input wire sct_pkg::sct_word_t INSN_I,
  input wire sct_pkg::sct_word_t PC_I,
  input wire sct_pkg::sct_word_t MSR_I,
  input wire sct_pkg::sct_dword_t GPR_A_I,
  input wire sct_pkg::sct_dword_t GPR_B_I,
  input wire logic LEGACY_MODE_I,
  // result side
  output logic REDIRECT_O,
  output sct_pkg::sct_word_t TARGET_O,
  output logic SVC_IRQ_O,
  output logic CTR_WE_O,
  output sct_pkg::sct_word_t CTR_O,
  output logic LR_WE_O,
  output sct_pkg::sct_word_t LR_O,
  output logic MSR_WE_O,
  output sct_pkg::sct_word_t MSR_O,
  output logic TRAP_O,
  output logic ILLEGAL_O,
  output logic SYS_CALL_O,
  // avalon-mm slave
  input wire logic [4:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic IRQ_O
);
  import sct_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // unsigned compares are plain magnitude on full-width operands, so a
  // narrower caller must widen its values before issue
  // masked compare shared by both trap forms
  function automatic logic trap_hit(input logic [4:0] tom, input sct_dword_t a,
                                    input sct_dword_t b);
    logic lt_s;
    logic gt_s;
    logic lt_u;
    logic gt_u;
    logic eq;
    lt_s = $signed(a) < $signed(b);
    gt_s = $signed(a) > $signed(b);
    lt_u = a < b;
    gt_u = a > b;
    eq = a == b;
    // mask bit 0 (msb of field) is signed less-than
    trap_hit = (tom[4] & lt_s) | (tom[3] & gt_s) | (tom[2] & eq)
             | (tom[1] & lt_u) | (tom[0] & gt_u);
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [5:0] opc; // primary opcode
  logic [6:0] handler_index_field; // vector index
  logic absolute_target_bit; // fixed vector select
  logic link_enable_bit; // write link register
  logic [4:0] trap_condition_mask; // trap conditions
  logic [9:0] xo; // extended opcode
  sct_dword_t signed_immediate; // widened immediate
  logic is_svc; // supervisor call issued
  logic is_sys; // same opcode, newer mode
  logic is_trap_rr; // register-register trap
  logic is_trap_imm; // immediate trap

  // decode is purely combinational from the issue inputs; nothing here
  // holds state, so an instruction that is not issued leaves no trace
  // svc spare fields (insn[15:12], insn[4:2]) steer no decode; they pass only into the count value
  assign opc = INSN_I[`SCT_OPC_HI:`SCT_OPC_LO];
  assign handler_index_field = INSN_I[`SCT_IDX_HI:`SCT_IDX_LO];
  assign absolute_target_bit = INSN_I[`SCT_ABS_POS];
  assign link_enable_bit = INSN_I[`SCT_LNK_POS];
  assign trap_condition_mask = INSN_I[`SCT_TOM_HI:`SCT_TOM_LO];
  assign xo = INSN_I[`SCT_XO_HI:`SCT_XO_LO];
  assign signed_immediate = {{48{INSN_I[15]}}, INSN_I[15:0]};
  // opcode 17 is shared; the mode input tells the two apart
  assign is_svc = ISSUE_I & (opc == `SCT_OP_SVC) & LEGACY_MODE_I;
  assign is_sys = ISSUE_I & (opc == `SCT_OP_SVC) & ~LEGACY_MODE_I;
  assign is_trap_rr = ISSUE_I & (opc == `SCT_OP_TRAP_RR) & (xo == `SCT_XO_TRAP_RR);
  assign is_trap_imm = ISSUE_I & (opc == `SCT_OP_TRAP_IMM);

  // ----------------------------------------------------------------
  // execution state
  // ----------------------------------------------------------------
  logic redirect_reg, redirect_next;
  sct_word_t target_reg, target_next;
  logic svc_reg, svc_next;
  sct_word_t ctr_reg, ctr_next;
  logic lr_we_reg, lr_we_next;
  sct_word_t lr_reg, lr_next;
  sct_word_t msr_reg, msr_next;
  logic trap_reg, trap_next;
  logic ill_reg, ill_next;
  logic sys_reg, sys_next;
  logic trap_en; // software gate on trap raising
  sct_word_t base; // base chosen by prefix select

  // every result is registered, so redirection trails the issue by one
  // cycle; the sequencer must look at these pulses before it acts on
  // the instruction that follows
  // compute results of the instruction being issued
  always_comb begin
    base = MSR_I[`SCT_MSR_IP] ? `SCT_BASE_HIGH : `SCT_BASE_LOW;
    redirect_next = 1'b0;
    target_next = target_reg; // last vector held for reading
    svc_next = 1'b0;
    ctr_next = ctr_reg;
    lr_we_next = 1'b0;
    lr_next = lr_reg;
    msr_next = msr_reg;
    trap_next = 1'b0;
    ill_next = 1'b0;
    sys_next = is_sys; // handed on to the system call path
    if (is_svc) begin
      svc_next = 1'b1;
      redirect_next = 1'b1;
      ctr_next = {INSN_I[15:0], MSR_I[15:0]};
      if (absolute_target_bit) begin
        target_next = base + `SCT_ABS_OFFSET;
      end else begin
        target_next = base + {19'h0_0000, 1'b1, handler_index_field, 5'h00};
      end
      if (link_enable_bit) begin
        lr_we_next = 1'b1;
        lr_next = PC_I + 32'h0000_0004;
      end
      // only the three bits below change; fp, me, al, ip, ir, dr pass
      msr_next = MSR_I;
      msr_next[`SCT_MSR_EE] = 1'b0;
      msr_next[`SCT_MSR_PR] = 1'b0;
      msr_next[`SCT_MSR_FE] = 1'b0;
      // no exception-register or cr0 port exists here at all
    end else if (is_trap_rr | is_trap_imm) begin
      if (!IS_64) begin
        ill_next = 1'b1;
      end else if (is_trap_rr) begin
        trap_next = trap_en & trap_hit(trap_condition_mask, GPR_A_I, GPR_B_I);
      end else begin
        trap_next = trap_en & trap_hit(trap_condition_mask, GPR_A_I,
                                       signed_immediate);
      end
    end
  end

  // one register stage for the whole result group keeps every output
  // free of decode glitches toward the sequencer
  // register the results
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      redirect_reg <= 1'b0;
      target_reg <= 32'h0000_0000;
      svc_reg <= 1'b0;
      ctr_reg <= 32'h0000_0000;
      lr_we_reg <= 1'b0;
      lr_reg <= 32'h0000_0000;
      msr_reg <= 32'h0000_0000;
      trap_reg <= 1'b0;
      ill_reg <= 1'b0;
      sys_reg <= 1'b0;
    end else begin
      redirect_reg <= redirect_next;
      target_reg <= target_next;
      svc_reg <= svc_next;
      ctr_reg <= ctr_next;
      lr_we_reg <= lr_we_next;
      lr_reg <= lr_next;
      msr_reg <= msr_next;
      trap_reg <= trap_next;
      ill_reg <= ill_next;
      sys_reg <= sys_next;
    end
  end

  assign REDIRECT_O = redirect_reg;
  assign TARGET_O = target_reg;
  assign SVC_IRQ_O = svc_reg;
  assign CTR_WE_O = svc_reg; // count write rides with the interrupt
  assign CTR_O = ctr_reg;
  assign LR_WE_O = lr_we_reg;
  assign LR_O = lr_reg;
  assign MSR_WE_O = svc_reg;
  assign MSR_O = msr_reg;
  assign TRAP_O = trap_reg;
  assign ILLEGAL_O = ill_reg;
  assign SYS_CALL_O = sys_reg;

  // ----------------------------------------------------------------
  // register bus, events and interrupt
  // ----------------------------------------------------------------
  // map: 0x00 ctrl (bit 0 lets traps through), 0x04 sticky events,
  // 0x08 interrupt mask, 0x0c last vector, 0x10 event-cycle count
  // every access takes one wait cycle: waitrequest drops in the second
  // cycle of the request, and read data stand in that same cycle
  // event bits: 0 svc, 1 trap, 2 illegal, 3 system call
  logic ack_reg, ack_next; // one wait cycle per access
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] ctrl_reg, ctrl_next;
  sct_events_t status_reg, status_next;
  sct_events_t mask_reg, mask_next;
  logic [15:0] count_reg, count_next; // events seen, wraps
  sct_events_t ev; // this cycle's events
  logic req; // access pending
  logic take; // access completes this edge

  assign req = AVS_READ_I | AVS_WRITE_I;
  assign take = req & ack_reg;
  assign ev = {sys_reg, ill_reg, trap_reg, svc_reg};
  assign trap_en = ctrl_reg[0];

  // decode, read mux and sticky status
  always_comb begin
    ack_next = req & ~ack_reg;
    rdata_next = rdata_reg;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    // counts cycles with any event; coincident events count once
    count_next = count_reg + 16'(|ev);
    if (ack_next & AVS_READ_I) begin
      case (AVS_ADDRESS_I)
        `SCT_REG_CTRL: rdata_next = ctrl_reg;
        `SCT_REG_STATUS: rdata_next = {28'h000_0000, status_reg | ev};
        `SCT_REG_MASK: rdata_next = {28'h000_0000, mask_reg};
        `SCT_REG_VECTOR: rdata_next = target_reg;
        `SCT_REG_COUNT: rdata_next = {16'h0000, count_reg};
        default: rdata_next = 32'h0000_0000; // unmapped reads zero
      endcase
    end
    if (take & AVS_WRITE_I) begin
      case (AVS_ADDRESS_I)
        `SCT_REG_CTRL: ctrl_next = {31'h0000_0000, AVS_WRITEDATA_I[0]};
        `SCT_REG_MASK: mask_next = AVS_WRITEDATA_I[3:0];
        default: ctrl_next = ctrl_reg; // others ignore writes
      endcase
    end
    // read clears; an event in the same cycle still sets
    if (take & AVS_READ_I & (AVS_ADDRESS_I == `SCT_REG_STATUS)) begin
      status_next = ev;
    end else begin
      status_next = status_reg | ev;
    end
  end

  // bus and event registers
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      ctrl_reg <= `SCT_CTRL_RST;
      mask_reg <= `SCT_MASK_RST;
      status_reg <= 4'h0;
      count_reg <= 16'h0000;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      status_reg <= status_next;
      count_reg <= count_next;
    end
  end

  assign AVS_WAITREQUEST_O = req & ~ack_reg;
  assign AVS_READDATA_O = rdata_reg;
  // level output; drops only through the status read or the mask
  assign IRQ_O = |(status_reg & mask_reg);

endmodule // sct_unit

// ### sct_checker.sv
// Purpose: port checks for sct_unit
// Assumes: bound onto every sct_unit instance
// Notes: vectors rebuilt from the instruction fields
`timescale 1ns/1ns
`include "sct_params.svh"
module sct_checker #(
  parameter bit IS_64 = 1'b1 // same as the unit
) (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic ISSUE_I,
  input wire sct_pkg::sct_word_t INSN_I,
  input wire sct_pkg::sct_word_t MSR_I,
  input wire logic LEGACY_MODE_I,
  input wire logic REDIRECT_O,
  input wire sct_pkg::sct_word_t TARGET_O,
  input wire logic SVC_IRQ_O,
  input wire sct_pkg::sct_word_t CTR_O,
  input wire logic LR_WE_O,
  input wire sct_pkg::sct_word_t MSR_O,
  input wire logic TRAP_O,
  input wire logic ILLEGAL_O,
  input wire logic SYS_CALL_O
);
  import sct_pkg::*;
  // --------
  // decode mirror
  // --------
  wire logic op17 = ISSUE_I && INSN_I[31:26] == `SCT_OP_SVC; // opcode 17 issued
  wire logic svc = op17 && LEGACY_MODE_I; // supervisor call
  wire logic trp = ISSUE_I && (INSN_I[31:26] == `SCT_OP_TRAP_IMM ||
    (INSN_I[31:26] == `SCT_OP_TRAP_RR && INSN_I[10:1] == `SCT_XO_TRAP_RR)); // either trap
  wire sct_word_t base = MSR_I[`SCT_MSR_IP] ? `SCT_BASE_HIGH : `SCT_BASE_LOW;
  wire sct_word_t rel_t = base + {19'h0_0000, 1'b1, INSN_I[11:5], 5'h00}; // indexed
  wire sct_word_t abs_t = base + `SCT_ABS_OFFSET; // absolute
  // --------
  // properties, all on the core clock
  // --------
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  a_svc_raise: assert property (svc |=> SVC_IRQ_O && REDIRECT_O)
    else $error("svc pulse missing");
  a_count_fill: assert property (svc |=>
    CTR_O == {$past(INSN_I[15:0]), $past(MSR_I[15:0])}) else $error("count value");
  a_rel_vector: assert property (svc && !INSN_I[1] |=> TARGET_O == $past(rel_t))
    else $error("indexed vector");
  a_abs_vector: assert property (svc && INSN_I[1] |=> TARGET_O == $past(abs_t))
    else $error("absolute vector");
  a_link_gate: assert property (svc |=> LR_WE_O == $past(INSN_I[0]))
    else $error("link write");
  a_state_clear: assert property (svc |=> MSR_O == ($past(MSR_I) & 32'hFFFF_37FF))
    else $error("state bits");
  a_sys_split: assert property (op17 && !LEGACY_MODE_I |=> SYS_CALL_O && !SVC_IRQ_O)
    else $error("mode split");
  a_trap_width: assert property (trp |=> ILLEGAL_O == !IS_64)
    else $error("illegal path");
  c_svc_link: cover property (svc && INSN_I[0]);
  c_trap_hit: cover property (TRAP_O);
  c_sys_call: cover property (SYS_CALL_O);
endmodule // sct_checker

bind sct_unit sct_checker #(.IS_64(IS_64)) sct_checker_inst (.REF_CLK_I(REF_CLK_I),
  .RSTN_I(RSTN_I), .ISSUE_I(ISSUE_I), .INSN_I(INSN_I), .MSR_I(MSR_I),
  .LEGACY_MODE_I(LEGACY_MODE_I), .REDIRECT_O(REDIRECT_O), .TARGET_O(TARGET_O),
  .SVC_IRQ_O(SVC_IRQ_O), .CTR_O(CTR_O), .LR_WE_O(LR_WE_O), .MSR_O(MSR_O),
  .TRAP_O(TRAP_O), .ILLEGAL_O(ILLEGAL_O), .SYS_CALL_O(SYS_CALL_O));

// ### sct_issue_model.sv
// Purpose: decode-side model feeding sct_unit
// Assumes: one instruction per issue call, two for a legacy-mode supervisor call (no-op issued first)
// Notes: lines inverted between issues so nothing stale matches
`timescale 1ns/1ns
module sct_issue_model (
  input wire logic clk_i,
  output logic issue_o,
  output sct_pkg::sct_word_t insn_o,
  output sct_pkg::sct_word_t pc_o,
  output sct_pkg::sct_word_t msr_o,
  output sct_pkg::sct_dword_t gpr_a_o,
  output sct_pkg::sct_dword_t gpr_b_o,
  output logic legacy_o
);
  import sct_pkg::*;
  // quiet issue side at time zero
  initial begin
    {issue_o, insn_o, msr_o, gpr_a_o, gpr_b_o} = '0;
    pc_o = 32'h0000_2000;
    legacy_o = 1'b1;
  end
  // one issue cycle; pc steps a word once taken
  task automatic drive(input sct_word_t i, m, input sct_dword_t a, b, input logic l);
    @(posedge clk_i);
    issue_o <= 1'b1;
    {insn_o, msr_o, gpr_a_o, gpr_b_o} <= {i, m, a, b};
    legacy_o <= l;
    @(posedge clk_i);
    issue_o <= 1'b0;
    {insn_o, msr_o, gpr_a_o, gpr_b_o} <= ~{i, m, a, b};
    pc_o <= pc_o + 32'h0000_0004;
  endtask
  // a supervisor call always follows a condition-register no-op
  task automatic issue(input sct_word_t i, m, input sct_dword_t a, b, input logic l);
    if (i[31:26] == 6'h11 && l)
      drive(32'h4C00_0382, m, a, b, l);
    drive(i, m, a, b, l);
  endtask
endmodule // sct_issue_model

// ### sct_unit_tb.sv
// Purpose: self-checking bench for sct_unit
// Assumes: model drives the issue side, bench drives the register bus
// Notes: expectations built from field layout only
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module sct_unit_tb;
  import sct_pkg::*;
  logic clk = 1'b0; // 100 MHz core clock
  logic rstn = 1'b0; // low for 16 cycles
  logic iss, leg, redir, svc, ctr_we, lr_we, msr_we, trap, ill, sysc, irq, wait_q;
  sct_word_t insn, pc, machine_state_reg, tgt, ctr, lr, msr_n, ins;
  sct_dword_t ga, gb;
  logic trap32, ill32; // narrow build trap outputs
  logic [4:0] addr = 5'h00;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, rd;
  sct_dword_t pa[3] = '{64'hFFFF_FFFF_FFFF_FFFF, 64'h5, 64'h1}; // first operands
  sct_dword_t pb[3] = '{64'h1, 64'h5, 64'hFFFF_FFFF_FFFF_FFFF}; // second operands
  int errors = 0;
  int compares = 0;
  always #5 clk = ~clk;
  sct_unit sct_unit_inst (.REF_CLK_I(clk), .RSTN_I(rstn), .ISSUE_I(iss), .INSN_I(insn),
    .PC_I(pc), .MSR_I(machine_state_reg), .GPR_A_I(ga), .GPR_B_I(gb), .LEGACY_MODE_I(leg),
    .REDIRECT_O(redir), .TARGET_O(tgt), .SVC_IRQ_O(svc), .CTR_WE_O(ctr_we), .CTR_O(ctr),
    .LR_WE_O(lr_we), .LR_O(lr), .MSR_WE_O(msr_we), .MSR_O(msr_n), .TRAP_O(trap),
    .ILLEGAL_O(ill), .SYS_CALL_O(sysc), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_q),
    .AVS_WRITE_I(wr_q), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wait_q), .IRQ_O(irq));
  sct_issue_model sct_issue_model_inst (.clk_i(clk), .issue_o(iss), .insn_o(insn),
    .pc_o(pc), .msr_o(machine_state_reg), .gpr_a_o(ga), .gpr_b_o(gb), .legacy_o(leg));
  // narrow build: same issue and bus lines, only its trap outputs are watched
  sct_unit #(.IS_64(1'b0)) sct_unit_n32_inst (.REF_CLK_I(clk), .RSTN_I(rstn), .ISSUE_I(iss),
    .INSN_I(insn), .PC_I(pc), .MSR_I(machine_state_reg), .GPR_A_I(ga), .GPR_B_I(gb), .LEGACY_MODE_I(leg),
    .REDIRECT_O(), .TARGET_O(), .SVC_IRQ_O(), .CTR_WE_O(), .CTR_O(), .LR_WE_O(), .LR_O(),
    .MSR_WE_O(), .MSR_O(), .TRAP_O(trap32), .ILLEGAL_O(ill32), .SYS_CALL_O(),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_q), .AVS_WRITE_I(wr_q), .AVS_WRITEDATA_I(wdat),
    .AVS_READDATA_O(), .AVS_WAITREQUEST_O(), .IRQ_O());
  // request held until waitrequest seen low; data taken at that edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    {addr, wr_q, rd_q, wdat} <= {a, w, ~w, d};
    do @(posedge clk); while (wait_q !== 1'b0);
    rd = rdat;
    {rd_q, wr_q} <= 2'b00;
    {addr, wdat} <= ~{a, d}; // stale lines must not matter once released
  endtask
  // issue, then let the result edge land
  task automatic run(input sct_word_t m, input sct_dword_t a, b, input logic l);
    sct_issue_model_inst.issue(ins, m, a, b, l);
    #1;
  endtask
  // mask order: signed lt, gt, eq, unsigned lt, gt
  function automatic logic hit(input logic [4:0] t, input sct_dword_t a, b);
    return |(t & {$signed(a) < $signed(b), $signed(a) > $signed(b), a == b, a < b, a > b});
  endfunction
  task automatic finish_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // whole run is about a hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, 5'h00, 32'h0000_0000);
    `CHK("ctrl", 32'h0000_0001, rd)
    bus(1'b0, 5'h14, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, rd)
    // indexed call with link, spare fields toggled
    for (int k = 0; k < 2; k++) begin
      ins = {6'h11, 10'h000, {4{k[0]}}, 7'h55, {3{k[0]}}, 2'b01};
      run(32'h0000_C8BF, 64'h0, 64'h0, 1'b1);
      `CHK("vector", 32'h0000_1AA0, tgt)
      `CHK("svc pulses", 4'hF, {svc, redir, ctr_we, msr_we})
      `CHK("count", {ins[15:0], 16'hC8BF}, ctr)
      `CHK("link", {1'b1, pc}, {lr_we, lr})
      `CHK("state", 32'h0000_00BF, msr_n)
    end
    // absolute call, high base, no link; then same opcode as system call
    ins = {6'h11, 10'h000, 4'h3, 7'h7F, 3'h2, 2'b10};
    run(32'h0000_0040, 64'h0, 64'h0, 1'b1);
    `CHK("abs vector", 32'hFFF0_1FE0, tgt)
    `CHK("no link", 1'b0, lr_we)
    `CHK("state kept", 32'h0000_0040, msr_n)
    run(32'h0000_0040, 64'h0, 64'h0, 1'b0);
    `CHK("sys call", 2'b10, {sysc, svc})
    bus(1'b1, 5'h0C, 32'h0000_0000);
    bus(1'b0, 5'h0C, 32'h0000_0000);
    `CHK("vector reg", 32'hFFF0_1FE0, rd)
    // every mask bit against three operand pairs
    for (int p = 0; p < 3; p++) begin
      for (int t = 0; t < 5; t++) begin
        ins = {6'h1F, 5'h10 >> t, 5'h03, 5'h04, 10'h044, 1'b0};
        run(32'h0000_0000, pa[p], pb[p], 1'b1);
        `CHK("trap", {hit(ins[25:21], pa[p], pb[p]), 1'b0}, {trap, ill})
        `CHK("narrow build", 2'b01, {trap32, ill32})
      end
    end
    // immediate of all ones must sign-extend
    for (int q = 0; q < 2; q++) begin
      ins = {6'h02, 5'h04, 5'h03, 16'hFFFF};
      run(32'h0000_0000, pa[0] >> (48 * q), 64'h0, 1'b1);
      `CHK("imm trap", 1'(q == 0), trap)
      `CHK("narrow imm", 2'b01, {trap32, ill32})
    end
    // trap enable cleared: a hitting trap stays quiet; then event count
    bus(1'b1, 5'h00, 32'h0000_0000);
    bus(1'b0, 5'h00, 32'h0000_0000);
    `CHK("ctrl off", 32'h0000_0000, rd)
    ins = {6'h1F, 5'h04, 5'h03, 5'h04, 10'h044, 1'b0};
    run(32'h0000_0000, pa[1], pb[1], 1'b1);
    `CHK("trap gated", 1'b0, trap)
    bus(1'b1, 5'h00, 32'h0000_0001);
    bus(1'b0, 5'h10, 32'h0000_0000);
    `CHK("event count", 32'h0000_000A, rd)
    // masked events keep the line low; unmasking raises it; read clears
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, 5'h08, 32'h0000_0002);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq raised", 1'b1, irq)
    bus(1'b0, 5'h04, 32'h0000_0000);
    `CHK("status", 32'h0000_000B, rd)
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq cleared", 1'b0, irq)
    finish_test();
  end
endmodule // sct_unit_tb
